// ---- core/sgc_regs.sv ----
// Global control registers 0x06 to 0x09: MII mode, null VID and storm threshold.
// Assumes the serial management front end gives one-cycle read and write strobes
// with a byte address, and that strap pins are stable around reset release.
`timescale 1ns/1ps
`default_nettype none
module sgc_regs
    import sgc_pkg::*;
#(
    parameter logic [SGC_CNT_W-1:0] CYC_100 = SGC_CNT_W'(SGC_CYC_100),
    parameter logic [SGC_CNT_W-1:0] CYC_10  = SGC_CNT_W'(SGC_CYC_10)
)(
    input  wire logic                          clk_i,
    input  wire logic                          reset_i,
    input  wire logic                          duplex_strap_pin_i,
    input  wire logic                          flow_ctrl_strap_pin_i,
    input  wire logic                          speed_strap_pin_i,
    input  wire logic [7:0]                    reg_addr_i,
    input  wire logic                          reg_wr_i,
    input  wire logic [7:0]                    reg_wr_data_i,
    input  wire logic                          reg_rd_i,
    input  wire logic [sgc_pkg::SGC_NUM_PORTS-1:0] storm_port_en_i,
    output logic [7:0]                         reg_rd_data_o,
    output logic                               mii_half_duplex_o,
    output logic                               mii_flow_ctrl_en_o,
    output logic                               mii_speed_10_o,
    output logic                               null_vid_replace_o,
    output logic [10:0]                        storm_threshold_o,
    output logic [sgc_pkg::SGC_NUM_PORTS-1:0]  storm_port_active_o,
    output logic                               storm_interval_tick_o
);
    import sgc_pkg::*;

    sgc_regs_s s_q;
    sgc_regs_s s_d;
    logic      tick;

    // Straps land one edge after reset release; writes wait until then
    always_comb
    begin
        s_d             = s_q;
        s_d.strap_done  = 1'b1;
        s_d.port_active = storm_port_en_i;
        if (!s_q.strap_done)
        begin
            s_d.mii_ctrl[SGC_BIT_HALF_DPX]  = duplex_strap_pin_i;
            s_d.mii_ctrl[SGC_BIT_FLOW_CTRL] = flow_ctrl_strap_pin_i;
            s_d.mii_ctrl[SGC_BIT_SPEED_10]  = speed_strap_pin_i;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                SGC_OFF_MII_CTRL: s_d.mii_ctrl = reg_wr_data_i;
                SGC_OFF_RATE_LO:  s_d.rate_lo  = reg_wr_data_i;
                SGC_OFF_FACT_A:   s_d.fact_a   = reg_wr_data_i;
                SGC_OFF_FACT_B:   s_d.fact_b   = reg_wr_data_i;
                default:          s_d.rate_lo  = s_q.rate_lo;
            endcase
        end
        // Read data held in a flop so the serial shifter sees a stable byte
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                SGC_OFF_MII_CTRL: s_d.rd_data = s_q.mii_ctrl;
                SGC_OFF_RATE_LO:  s_d.rd_data = s_q.rate_lo;
                SGC_OFF_FACT_A:   s_d.rd_data = s_q.fact_a;
                SGC_OFF_FACT_B:   s_d.rd_data = s_q.fact_b;
                default:          s_d.rd_data = SGC_RD_UNMAPPED;
            endcase
        end
    end

    // Constant reset; strap levels are caught by the clocked load above
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s_q.strap_done  <= 1'b0;
            s_q.mii_ctrl    <= SGC_RST_MII_CTRL;
            s_q.rate_lo     <= SGC_RST_RATE_LO;
            s_q.fact_a      <= SGC_RST_FACT_A;
            s_q.fact_b      <= SGC_RST_FACT_B;
            s_q.rd_data     <= SGC_RD_UNMAPPED;
            s_q.port_active <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Interval timer paced by the current MII speed
    sgc_interval_timer #(
        .CYC_100 (CYC_100),
        .CYC_10  (CYC_10)
    ) u_timer (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .speed_10_i (s_q.mii_ctrl[SGC_BIT_SPEED_10]),
        .tick_o     (tick)
    );

    // Outputs taken directly from register fields
    assign reg_rd_data_o         = s_q.rd_data;
    assign mii_half_duplex_o     = s_q.mii_ctrl[SGC_BIT_HALF_DPX];
    assign mii_flow_ctrl_en_o    = s_q.mii_ctrl[SGC_BIT_FLOW_CTRL];
    assign mii_speed_10_o        = s_q.mii_ctrl[SGC_BIT_SPEED_10];
    assign null_vid_replace_o    = s_q.mii_ctrl[SGC_BIT_NULL_VID];
    assign storm_threshold_o     = {s_q.mii_ctrl[SGC_RATE_HI_MSB:0], s_q.rate_lo};
    assign storm_port_active_o   = s_q.port_active;
    assign storm_interval_tick_o = tick;

    sequence s_strap_cycle;
        !s_q.strap_done;
    endsequence

    sequence s_ctrl_write;
        s_q.strap_done && reg_wr_i && (reg_addr_i == SGC_OFF_MII_CTRL);
    endsequence

    property p_duplex_strap;
        @(posedge clk_i) disable iff (reset_i)
        s_strap_cycle |=> mii_half_duplex_o == $past(duplex_strap_pin_i);
    endproperty
    a_duplex_strap: assert property (p_duplex_strap) else $error("duplex strap not loaded");

    property p_flow_strap;
        @(posedge clk_i) disable iff (reset_i)
        s_strap_cycle |=> mii_flow_ctrl_en_o == $past(flow_ctrl_strap_pin_i);
    endproperty
    a_flow_strap: assert property (p_flow_strap) else $error("flow strap not loaded");

    property p_speed_strap;
        @(posedge clk_i) disable iff (reset_i)
        s_strap_cycle |=> mii_speed_10_o == $past(speed_strap_pin_i);
    endproperty
    a_speed_strap: assert property (p_speed_strap) else $error("speed strap not loaded");

    property p_duplex_write;
        @(posedge clk_i) disable iff (reset_i)
        s_ctrl_write |=> mii_half_duplex_o == $past(reg_wr_data_i[SGC_BIT_HALF_DPX]);
    endproperty
    a_duplex_write: assert property (p_duplex_write) else $error("duplex write lost");

    property p_flow_write;
        @(posedge clk_i) disable iff (reset_i)
        s_ctrl_write |=> mii_flow_ctrl_en_o == $past(reg_wr_data_i[SGC_BIT_FLOW_CTRL]);
    endproperty
    a_flow_write: assert property (p_flow_write) else $error("flow write lost");

    property p_speed_write;
        @(posedge clk_i) disable iff (reset_i)
        s_ctrl_write |=> mii_speed_10_o == $past(reg_wr_data_i[SGC_BIT_SPEED_10]);
    endproperty
    a_speed_write: assert property (p_speed_write) else $error("speed write lost");

    property p_nullvid_write;
        @(posedge clk_i) disable iff (reset_i)
        s_ctrl_write |=> null_vid_replace_o == $past(reg_wr_data_i[SGC_BIT_NULL_VID]);
    endproperty
    a_nullvid_write: assert property (p_nullvid_write) else $error("null vid write lost");

    property p_threshold_write;
        @(posedge clk_i) disable iff (reset_i)
        s_q.strap_done && reg_wr_i && (reg_addr_i == SGC_OFF_RATE_LO)
        |=> storm_threshold_o[7:0] == $past(reg_wr_data_i);
    endproperty
    a_threshold_write: assert property (p_threshold_write) else $error("rate write lost");

    property p_threshold_reset;
        @(posedge clk_i) disable iff (reset_i)
        s_strap_cycle |-> storm_threshold_o == {SGC_RST_MII_CTRL[SGC_RATE_HI_MSB:0], SGC_RST_RATE_LO};
    endproperty
    a_threshold_reset: assert property (p_threshold_reset) else $error("rate reset wrong");

    property p_port_gate;
        @(posedge clk_i) disable iff (reset_i)
        1'b1 |=> storm_port_active_o == $past(storm_port_en_i);
    endproperty
    a_port_gate: assert property (p_port_gate) else $error("port storm gate wrong");

    // Reads of the control byte, taken before any same-cycle write
    sequence s_ctrl_read;
        reg_rd_i && (reg_addr_i == SGC_OFF_MII_CTRL);
    endsequence

    // A write racing the strap load is dropped, threshold keeps its reset value
    property p_strap_write_refused;
        @(posedge clk_i) disable iff (reset_i)
        s_strap_cycle |=> storm_threshold_o == {SGC_RST_MII_CTRL[SGC_RATE_HI_MSB:0], SGC_RST_RATE_LO};
    endproperty
    a_strap_write_refused: assert property (p_strap_write_refused) else $error("strap cycle write taken");

    // Control byte read back matches the mode outputs it drives
    property p_ctrl_read;
        @(posedge clk_i) disable iff (reset_i)
        s_ctrl_read |=> (reg_rd_data_o[SGC_BIT_HALF_DPX:SGC_BIT_NULL_VID]
            == $past({mii_half_duplex_o, mii_flow_ctrl_en_o, mii_speed_10_o, null_vid_replace_o}))
            && (reg_rd_data_o[SGC_RATE_HI_MSB:0] == $past(storm_threshold_o[10:8]));
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read back wrong");

    // Low threshold byte read back matches the threshold output
    property p_rate_read;
        @(posedge clk_i) disable iff (reset_i)
        reg_rd_i && (reg_addr_i == SGC_OFF_RATE_LO) |=> reg_rd_data_o == $past(storm_threshold_o[7:0]);
    endproperty
    a_rate_read: assert property (p_rate_read) else $error("rate read back wrong");

    // Upper threshold bits ride in the low bits of the control byte
    property p_rate_hi_write;
        @(posedge clk_i) disable iff (reset_i)
        s_ctrl_write |=> storm_threshold_o[10:8] == $past(reg_wr_data_i[SGC_RATE_HI_MSB:0]);
    endproperty
    a_rate_hi_write: assert property (p_rate_hi_write) else $error("rate high write lost");

    // Mode outputs only move on a control write or the strap load, never on other traffic
    property p_ctrl_hold;
        @(posedge clk_i) disable iff (reset_i)
        s_q.strap_done && !(reg_wr_i && (reg_addr_i == SGC_OFF_MII_CTRL))
        |=> $stable({mii_half_duplex_o, mii_flow_ctrl_en_o, mii_speed_10_o, null_vid_replace_o});
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("mode output moved without write");

    // Low threshold byte only moves on its own write
    property p_rate_hold;
        @(posedge clk_i) disable iff (reset_i)
        s_q.strap_done && !(reg_wr_i && (reg_addr_i == SGC_OFF_RATE_LO))
        |=> $stable(storm_threshold_o[7:0]);
    endproperty
    a_rate_hold: assert property (p_rate_hold) else $error("rate moved without write");
endmodule : sgc_regs
`default_nettype wire

// ---- core/sgc_pkg.sv ----
// Constants and state types for the switch global control registers 0x06 to 0x09.
// Assumes a single 25 MHz core clock and a serial management front end
// that presents byte-wide register reads and writes.
//
// Behaviour
// - Control bit 6 set gives half-duplex MII, cleared gives full duplex.
// - Duplex bit loads from duplex strap at reset; low strap means full duplex.
// - Control bit 5 set enables full-duplex pause flow control on MII.
// - Flow control bit loads from its strap at reset; low strap disables it.
// - Control bit 4 set runs the MII at 10 Mbps.
// - Control bit 4 cleared runs the MII at 100 Mbps.
// - Control bit 3 set replaces a null VLAN id with the port default id.
// - 11-bit storm threshold: bits 10..8 in control bits 2..0, low byte next register.
// - Storm interval at 100 Mbps is taken as 67 ms.
// - Storm interval at 10 Mbps is 500 ms.
// - Storm threshold resets to 0x063, about one percent of line rate.
// - Storm limiting applies only on ports whose own storm enable is set.
package sgc_pkg;
    // Register offsets
    localparam logic [7:0] SGC_OFF_MII_CTRL  = 8'h06;
    localparam logic [7:0] SGC_OFF_RATE_LO   = 8'h07;
    localparam logic [7:0] SGC_OFF_FACT_A    = 8'h08;
    localparam logic [7:0] SGC_OFF_FACT_B    = 8'h09;
    // Field positions in the MII control register, and the port count
    localparam int SGC_BIT_HALF_DPX  = 6;
    localparam int SGC_BIT_FLOW_CTRL = 5;
    localparam int SGC_BIT_SPEED_10  = 4;
    localparam int SGC_BIT_NULL_VID  = 3;
    localparam int SGC_RATE_HI_MSB   = 2;
    localparam int SGC_NUM_PORTS     = 3;
    // Reset values; strap-loaded bits start at their pull-down value
    localparam logic [7:0] SGC_RST_MII_CTRL = 8'h00;
    localparam logic [7:0] SGC_RST_RATE_LO  = 8'h63;
    localparam logic [7:0] SGC_RST_FACT_A   = 8'h4e;
    localparam logic [7:0] SGC_RST_FACT_B   = 8'h24;
    localparam logic [7:0] SGC_RD_UNMAPPED  = 8'h00;
    // Storm measurement timing
    localparam longint SGC_CLK_HZ          = 25000000;
    localparam longint SGC_INTERVAL_100_MS = 67;
    localparam longint SGC_INTERVAL_10_MS  = 500;
    localparam longint SGC_CYC_100 = SGC_INTERVAL_100_MS * SGC_CLK_HZ / 1000;
    localparam longint SGC_CYC_10  = SGC_INTERVAL_10_MS * SGC_CLK_HZ / 1000;
    localparam int     SGC_CNT_W   = 24;

    // Register-bank state
    typedef struct packed {
        logic                     strap_done;
        logic [7:0]               mii_ctrl;
        logic [7:0]               rate_lo;
        logic [7:0]               fact_a;
        logic [7:0]               fact_b;
        logic [7:0]               rd_data;
        logic [SGC_NUM_PORTS-1:0] port_active;
    } sgc_regs_s;

    // Interval timer state
    typedef struct packed {
        logic [SGC_CNT_W-1:0] count;
        logic                 speed_10;
        logic                 tick;
    } sgc_timer_s;
endpackage : sgc_pkg

// ---- core/sgc_interval_timer.sv ----
// Storm measurement interval timer: one-cycle tick at the end of each interval.
// Assumes the speed select comes from a register in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module sgc_interval_timer
    import sgc_pkg::*;
#(
    parameter logic [SGC_CNT_W-1:0] CYC_100 = SGC_CNT_W'(SGC_CYC_100),
    parameter logic [SGC_CNT_W-1:0] CYC_10  = SGC_CNT_W'(SGC_CYC_10)
)(
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic speed_10_i,
    output logic      tick_o
);
    import sgc_pkg::*;

    sgc_timer_s s_q;
    sgc_timer_s s_d;
    logic [SGC_CNT_W-1:0] period;

    // Interval length follows the port speed
    assign period = s_q.speed_10 ? CYC_10 : CYC_100;

    // Counter restarts on a speed change so no interval mixes two rates
    always_comb
    begin
        s_d          = s_q;
        s_d.speed_10 = speed_10_i;
        s_d.tick     = 1'b0;
        if (speed_10_i != s_q.speed_10)
        begin
            s_d.count = '0;
        end
        else if (s_q.count >= period - SGC_CNT_W'(1))
        begin
            s_d.count = '0;
            s_d.tick  = 1'b1;
        end
        else
        begin
            s_d.count = s_q.count + SGC_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tick_o = s_q.tick;

    // Tick comes exactly when the count wraps at the current period
    property p_tick_at_wrap;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.count == period - SGC_CNT_W'(1)) && (speed_10_i == s_q.speed_10) |=> tick_o;
    endproperty
    a_tick_at_wrap: assert property (p_tick_at_wrap) else $error("interval tick missing");

    // Ticks are never closer than nine cycles apart (eight quiet cycles after each tick)
    property p_tick_spacing;
        @(posedge clk_i) disable iff (reset_i)
        tick_o |=> !tick_o [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("interval ticks too close");
endmodule : sgc_interval_timer
`default_nettype wire

// ---- verification/sgc_host_model.sv ----
// Management host model: byte register writes and reads on the strobe port.
// Assumes the bench calls wr and rd one at a time, never from two processes.
`timescale 1ns/1ps
`default_nettype none
module sgc_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rd_data_i,
    output logic [7:0]      addr_o,
    output logic            wr_o,
    output logic [7:0]      wr_data_o,
    output logic            rd_o
);
    // Idle bus at time zero
    initial
    begin
        addr_o    = 8'h00;
        wr_o      = 1'b0;
        wr_data_o = 8'h00;
        rd_o      = 1'b0;
    end

    // One-cycle write strobe; data scrambled after release so stale data never helps
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o    <= a;
        wr_data_o <= d;
        wr_o      <= 1'b1;
        @(posedge clk_i);
        wr_o      <= 1'b0;
        wr_data_o <= ~d;
        #1;
    endtask : wr

    // One-cycle read strobe; data is registered, taken after the next edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o   <= 1'b1;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rd_data_i;
    endtask : rd
endmodule : sgc_host_model
`default_nettype wire

// ---- verification/switch_global_control_regs_test.sv ----
// Bench for the global control registers: straps, fields, storm timer, port gate.
// Assumes small interval parameters so the storm tick is seen in a short run.
`timescale 1ns/1ps
`default_nettype none
module switch_global_control_regs_test;
    import sgc_pkg::*;
    localparam logic [SGC_CNT_W-1:0] C100 = 24'h000014;
    localparam logic [SGC_CNT_W-1:0] C10  = 24'h000028;
    logic       clk_i;
    logic       reset_i;
    logic [2:0] strap;
    logic [7:0] addr, wdat, rdat, v;
    logic       wr, rd;
    logic [2:0] port_en, port_act;
    logic       half, flow, spd10, nvid, tick;
    logic [10:0] thr;
    int         err_count;
    int         num_checks;

    sgc_host_model host (.clk_i(clk_i), .rd_data_i(rdat), .addr_o(addr), .wr_o(wr),
                         .wr_data_o(wdat), .rd_o(rd));

    sgc_regs #(.CYC_100(C100), .CYC_10(C10)) uut (
        .clk_i(clk_i), .reset_i(reset_i), .duplex_strap_pin_i(strap[2]),
        .flow_ctrl_strap_pin_i(strap[1]), .speed_strap_pin_i(strap[0]),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wr_data_i(wdat), .reg_rd_i(rd),
        .storm_port_en_i(port_en), .reg_rd_data_o(rdat), .mii_half_duplex_o(half),
        .mii_flow_ctrl_en_o(flow), .mii_speed_10_o(spd10), .null_vid_replace_o(nvid),
        .storm_threshold_o(thr), .storm_port_active_o(port_act),
        .storm_interval_tick_o(tick));

    // Free-running 25 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // Reset with a strap pattern {duplex, flow, speed}; first access three edges on
    task automatic do_reset(input logic [2:0] s);
        @(posedge clk_i);
        strap   <= s;
        reset_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : do_reset

    // Cycles between two storm ticks, each wait bounded; always step one edge
    // first, since the first tick after a speed change is one cycle late
    task automatic period(input int exp);
        int n;
        int g;
        n = 0;
        g = 0;
        do
        begin
            @(posedge clk_i);
            #1;
            g++;
        end while (tick !== 1'b1 && g < 400);
        do
        begin
            @(posedge clk_i);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 400);
        if (g >= 400 || n >= 400)
        begin
            err_count++;
            wrap_up();
        end
        chk(11'(n), 11'(exp));
    endtask : period

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        wrap_up();
    end

    // Main sequence
    initial
    begin
        err_count  = 0;
        num_checks = 0;
        reset_i    = 1'b1;
        strap      = 3'b000;
        port_en    = 3'b000;
        do_reset(3'b101);
        chk(11'({half, flow, spd10}), 11'h005);
        host.rd(8'h06, v);
        chk(11'(v), 11'h050);
        chk(thr, 11'h063);
        host.rd(8'h07, v);
        chk(11'(v), 11'h063);
        host.rd(8'h08, v);
        chk(11'(v), 11'h04e);
        host.rd(8'h09, v);
        chk(11'(v), 11'h024);
        host.rd(8'h0a, v);
        chk(11'(v), 11'h000);
        do_reset(3'b010);
        chk(11'({half, flow, spd10}), 11'h002);
        $display("strap and reset test done");
        // One control bit at a time, bits 3 to 6
        for (int i = 3; i < 7; i++)
        begin
            host.wr(8'h06, 8'h01 << i);
            chk(11'({half, flow, spd10, nvid}), 11'((8'h01 << i) >> 3));
        end
        $display("mode bit test done");
        host.wr(8'h06, 8'h05);
        host.wr(8'h07, 8'h9a);
        host.wr(8'h0b, 8'hff);
        chk(thr, 11'h59a);
        host.rd(8'h06, v);
        chk(11'(v), 11'h005);
        host.wr(8'h08, 8'h81);
        host.rd(8'h08, v);
        chk(11'(v), 11'h081);
        $display("threshold test done");
        host.wr(8'h06, 8'h00);
        period(int'(C100));
        host.wr(8'h06, 8'h10);
        period(int'(C10));
        $display("interval test done");
        @(posedge clk_i);
        port_en <= 3'b101;
        repeat (2) @(posedge clk_i);
        #1;
        chk(11'(port_act), 11'h005);
        $display("port gate test done");
        wrap_up();
    end
endmodule : switch_global_control_regs_test
`default_nettype wire
